/* core/tsl_defines.vh */
// Shared offsets, field positions, codes and reset values of the transport status log block
`ifndef TSL_DEFINES_VH
`define TSL_DEFINES_VH

// Register byte offsets
`define TSL_OFS_CMD_LO 5'h00
`define TSL_OFS_CMD_HI 5'h04
`define TSL_OFS_ATA_STATUS 5'h08
`define TSL_OFS_PAGE_DATA 5'h0c
`define TSL_OFS_DEV_STATE 5'h10

// Field positions in the command registers
`define TSL_LO_FEATURE 7:0
`define TSL_LO_COUNT 15:8
`define TSL_LO_LBA_LOW 23:16
`define TSL_LO_LBA_MID 31:24
`define TSL_HI_LBA_HIGH 7:0
`define TSL_HI_COUNT_PREV 15:8
`define TSL_HI_MID_PREV 23:16
`define TSL_HI_COMMAND 31:24

// Status register bit positions
`define TSL_ST_ACCEPTED 0
`define TSL_ST_FAILED 1
`define TSL_ST_PAGE_BUSY 2
`define TSL_ST_SEG_INIT 3

// Taskfile codes
`define TSL_CMD_SMART 8'hb0
`define TSL_CMD_READ_LOG_EXT 8'h2f
`define TSL_CMD_WRITE_LOG_EXT 8'h3f
`define TSL_FEAT_SMART_RD_LOG 8'hd5
`define TSL_FEAT_SMART_WR_LOG 8'hd6
`define TSL_SMART_CYL_LOW 8'h4f
`define TSL_SMART_CYL_HIGH 8'hc2
`define TSL_PAGE_STATUS 8'he0
`define TSL_PAGE_DATA 8'he1
`define TSL_COUNT_ONE 8'h01
`define TSL_COUNT_EIGHT 8'h08

// Status page content
`define TSL_FORMAT_VERSION 16'h0003
`define TSL_SPEC_LEVEL 16'h0001
`define TSL_EXT_BUSY 16'hffff
`define TSL_EXT_IDLE 16'h0000
`define TSL_PAGE_LAST_WORD 7'h7f

// Drive status codes
`define TSL_DS_ACTIVE 8'h00
`define TSL_DS_STANDBY 8'h01
`define TSL_DS_SLEEP 8'h02
`define TSL_DS_SELF_TEST 8'h03
`define TSL_DS_OFFLINE 8'h04
`define TSL_DS_TRANSPORT 8'h05

// Reset values
`define TSL_RST_WORD 32'h00000000
`define TSL_RST_BYTE 8'h00

`endif

/* core/tsl_fifo.v */
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/10ps
module tsl_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  // Drain side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready_out = (count_reg != DEPTH[AW:0]);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // tsl_fifo

/* core/tsl_cmd_decode.v */
// Taskfile decoder that classifies log page status and data transfer commands
`timescale 1ns/10ps
`include "tsl_defines.vh"
module tsl_cmd_decode (
  // Taskfile fields
  input wire [7:0] command_in,
  input wire [7:0] feature_in,
  input wire [7:0] count_in,
  input wire [7:0] count_prev_in,
  input wire [7:0] lba_low_in,
  input wire [7:0] lba_mid_in,
  input wire [7:0] mid_prev_in,
  input wire [7:0] lba_high_in,
  // Classification
  output wire status_req_out,
  output wire data_req_out,
  output wire data_write_out
);
  wire smart_sig;
  wire smart_status;
  wire smart_data;
  wire ext_zero;
  wire ext_status;
  wire ext_data;

  assign smart_sig = (command_in == `TSL_CMD_SMART) && (lba_mid_in == `TSL_SMART_CYL_LOW)
    && (lba_high_in == `TSL_SMART_CYL_HIGH);
  assign smart_status = smart_sig && (feature_in == `TSL_FEAT_SMART_RD_LOG)
    && (count_in == `TSL_COUNT_ONE) && (lba_low_in == `TSL_PAGE_STATUS);
  assign smart_data = smart_sig && (lba_low_in == `TSL_PAGE_DATA)
    && ((feature_in == `TSL_FEAT_SMART_RD_LOG) || (feature_in == `TSL_FEAT_SMART_WR_LOG));
  assign ext_zero = (count_prev_in == `TSL_RST_BYTE) && (lba_mid_in == `TSL_RST_BYTE)
    && (mid_prev_in == `TSL_RST_BYTE);
  // Status page read through the extended log opcode; feature bytes are ignored
  assign ext_status = (command_in == `TSL_CMD_READ_LOG_EXT) && ext_zero
    && (count_in == `TSL_COUNT_ONE) && (lba_low_in == `TSL_PAGE_STATUS); // [RULE6]
  assign ext_data = ((command_in == `TSL_CMD_READ_LOG_EXT)
    || (command_in == `TSL_CMD_WRITE_LOG_EXT)) && ext_zero && (lba_low_in == `TSL_PAGE_DATA)
    && ((count_in == `TSL_COUNT_ONE) || (count_in == `TSL_COUNT_EIGHT)); // [RULE1]

  assign status_req_out = smart_status || ext_status; // [RULE5]
  assign data_req_out = smart_data || ext_data;
  assign data_write_out = (smart_data && (feature_in == `TSL_FEAT_SMART_WR_LOG))
    || (ext_data && (command_in == `TSL_CMD_WRITE_LOG_EXT));
endmodule // tsl_cmd_decode

/* core/tsl_status_log.v */
// Transport status log access: taskfile registers, status page generator and Avalon-MM slave
//
// Function
// (RULE1) A data log transfer by extended log uses read or write opcode, data page, count 1 or 8, zero prev count and mid.
// (RULE2) After a transport command the ATA status tells only whether it was accepted or failed, not its completion.
// (RULE3) Reading the status log page returns the transport status, which the host may poll.
// (RULE4) A status page read is accepted at any time and leaves power state and background work untouched; here one is refused while a page is still pending.
// (RULE5) A status request by SMART uses the SMART opcode, read-log feature, count 1, status page and signature cylinders.
// (RULE6) A status request by extended log read uses that opcode, status page, count 1, zero prev count and mid.
// (RULE7) The first page word holds the response format version, fixed at three.
// (RULE8) The second page word holds the vendor-chosen implementation version.
// (RULE9) The third page word holds the supported transport specification level, one.
// (RULE10) Flag bit 0 is set once a write-same has written every block without error; bits 1 to 31 read zero.
// (RULE11) The segment-initialized flag clears whenever any user block is written, cached or not.
// (RULE12) The segment-initialized flag also clears on any capacity change by max-address set or config overlay.
// (RULE13) The segment-initialized flag survives a power cycle through nonvolatile storage.
// (RULE14) The drive-status byte encodes idle 0, standby 1, sleep 2, self-test 3, offline collection 4, transport 5.
// (RULE15) The extended status code reads all ones while a transport command runs in the background.
// (RULE16) Multi-byte page fields are stored least significant byte first and reserved bytes read zero.
`timescale 1ns/10ps
`include "tsl_defines.vh"
module tsl_status_log #(
  parameter IMPL_VERSION = 16'h0100,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Avalon-MM slave
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output wire [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Drive condition from the rest of the device
  input wire standby_in,
  input wire sleep_in,
  input wire drive_self_test_in,
  input wire offline_data_collection_in,
  input wire command_transport_busy_in,
  input wire lba_write_in,
  input wire max_address_set_in,
  input wire config_overlay_in,
  input wire write_same_done_in,
  // Nonvolatile segment flag storage
  input wire nv_seg_flag_in,
  output wire nv_seg_flag_out,
  output wire nv_store_out,
  // Data log transfer request
  output wire data_log_req_out,
  output wire data_log_write_out
);
  reg [31:0] cmd_lo_reg;
  reg [31:0] cmd_hi_reg;
  reg issue_reg;
  reg accepted_reg;
  reg failed_reg;
  reg seg_flag_reg;
  reg nv_loaded_reg;
  reg nv_store_reg;
  reg [7:0] drive_state_reg;
  reg gen_active_reg;
  reg [6:0] gen_idx_reg;
  reg data_req_reg;
  reg data_write_reg;
  reg [31:0] readdata_reg;
  reg waitrequest_reg;
  reg [7:0] drive_state_next;
  reg [31:0] page_word;
  reg [31:0] rd_value;
  reg [31:0] cmd_lo_next;
  reg [31:0] cmd_hi_next;
  reg [31:0] readdata_next;
  reg waitrequest_next;
  reg gen_active_next;
  reg [6:0] gen_idx_next;
  reg seg_flag_next;
  reg nv_store_next;
  wire status_req;
  wire data_req;
  wire data_write;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire fifo_pop;
  wire page_busy;
  wire bus_req;
  wire rd_data_sel;
  wire serve;
  wire hi_write;
  wire [15:0] ext_status;
  wire [31:0] flags_word;
  wire page_start;
  wire cmd_ok;

  tsl_cmd_decode u_decode (
    .command_in(cmd_hi_reg[`TSL_HI_COMMAND]),
    .feature_in(cmd_lo_reg[`TSL_LO_FEATURE]),
    .count_in(cmd_lo_reg[`TSL_LO_COUNT]),
    .count_prev_in(cmd_hi_reg[`TSL_HI_COUNT_PREV]),
    .lba_low_in(cmd_lo_reg[`TSL_LO_LBA_LOW]),
    .lba_mid_in(cmd_lo_reg[`TSL_LO_LBA_MID]),
    .mid_prev_in(cmd_hi_reg[`TSL_HI_MID_PREV]),
    .lba_high_in(cmd_hi_reg[`TSL_HI_LBA_HIGH]),
    .status_req_out(status_req),
    .data_req_out(data_req),
    .data_write_out(data_write)
  );

  tsl_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(gen_active_reg),
    .in_data_in(page_word),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_pop)
  );

  // Bus handshake: one wait cycle, more while a page data read stalls, then waitrequest low for exactly one edge
  assign bus_req = (avs_read_in || avs_write_in) && waitrequest_reg;
  assign page_busy = gen_active_reg || fifo_out_valid;
  assign rd_data_sel = avs_read_in && (avs_address_in == `TSL_OFS_PAGE_DATA);
  // A page data read stalls while the page is still being produced but the FIFO is empty
  assign serve = bus_req && !(rd_data_sel && gen_active_reg && !fifo_out_valid);
  assign fifo_pop = serve && rd_data_sel && fifo_out_valid;
  assign hi_write = serve && avs_write_in && (avs_address_in == `TSL_OFS_CMD_HI);
  // A status request while a page is still pending is refused
  assign page_start = issue_reg && status_req && !page_busy; // [RULE3] [RULE4]
  assign cmd_ok = (status_req && !page_busy) || data_req;

  // Background transport work shows as all ones, otherwise the idle code
  assign ext_status = command_transport_busy_in ? `TSL_EXT_BUSY : `TSL_EXT_IDLE; // [RULE15]
  assign flags_word = {31'h00000000, seg_flag_reg}; // [RULE10]

  // Page words are built byte 0 in bits 7:0, so fields land low byte first
  always @* begin
    page_word = `TSL_RST_WORD; // [RULE16]
    case (gen_idx_reg)
      7'h00: page_word = {IMPL_VERSION[15:0], `TSL_FORMAT_VERSION}; // [RULE7] [RULE8]
      7'h01: page_word = {flags_word[15:0], `TSL_SPEC_LEVEL}; // [RULE9] [RULE10]
      7'h02: page_word = {`TSL_RST_BYTE, drive_state_reg, flags_word[31:16]}; // [RULE14]
      7'h03: page_word = {ext_status, `TSL_RST_BYTE, `TSL_RST_BYTE}; // [RULE15] [RULE16]
      default: page_word = `TSL_RST_WORD; // [RULE16]
    endcase
  end

  // Drive status code, background work taking priority over power states
  always @* begin
    drive_state_next = `TSL_DS_ACTIVE;
    if (command_transport_busy_in) begin
      drive_state_next = `TSL_DS_TRANSPORT; // [RULE14]
    end else if (offline_data_collection_in) begin
      drive_state_next = `TSL_DS_OFFLINE; // [RULE14]
    end else if (drive_self_test_in) begin
      drive_state_next = `TSL_DS_SELF_TEST; // [RULE14]
    end else if (sleep_in) begin
      drive_state_next = `TSL_DS_SLEEP; // [RULE14]
    end else if (standby_in) begin
      drive_state_next = `TSL_DS_STANDBY; // [RULE14]
    end
  end

  // Register read multiplexer
  always @* begin
    rd_value = `TSL_RST_WORD;
    case (avs_address_in)
      `TSL_OFS_CMD_LO: rd_value = cmd_lo_reg;
      `TSL_OFS_CMD_HI: rd_value = cmd_hi_reg;
      `TSL_OFS_ATA_STATUS: rd_value = {28'h0000000, seg_flag_reg, page_busy, failed_reg,
        accepted_reg}; // [RULE2]
      `TSL_OFS_PAGE_DATA: rd_value = fifo_out_valid ? fifo_out_data : `TSL_RST_WORD; // [RULE3]
      `TSL_OFS_DEV_STATE: rd_value = {24'h000000, drive_state_reg};
      default: rd_value = `TSL_RST_WORD;
    endcase
  end

  // Avalon slave next values; waitrequest drops only in the cycle after a served edge
  always @* begin
    waitrequest_next = !serve;
    readdata_next = readdata_reg;
    cmd_lo_next = cmd_lo_reg;
    cmd_hi_next = cmd_hi_reg;
    if (serve) begin
      readdata_next = avs_read_in ? rd_value : `TSL_RST_WORD;
      if (avs_write_in && (avs_address_in == `TSL_OFS_CMD_LO)) begin
        cmd_lo_next = avs_writedata_in;
      end
      if (hi_write) begin
        cmd_hi_next = avs_writedata_in;
      end
    end
  end

  // Avalon slave and taskfile registers
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_lo_reg <= `TSL_RST_WORD;
      cmd_hi_reg <= `TSL_RST_WORD;
      issue_reg <= 1'b0;
      readdata_reg <= `TSL_RST_WORD;
      waitrequest_reg <= 1'b1;
    end else begin
      issue_reg <= hi_write;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
      cmd_lo_reg <= cmd_lo_next;
      cmd_hi_reg <= cmd_hi_next;
    end
  end

  // Command outcome; a status read while a page is still pending is refused
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      accepted_reg <= 1'b0;
      failed_reg <= 1'b0;
      data_req_reg <= 1'b0;
      data_write_reg <= 1'b0;
    end else begin
      data_req_reg <= 1'b0;
      if (issue_reg) begin
        // Only accept or fail is reported; transport completion never shows here
        accepted_reg <= cmd_ok; // [RULE2]
        failed_reg <= !cmd_ok; // [RULE2]
        data_req_reg <= data_req; // [RULE1]
        // Direction follows the last accepted data command only
        if (data_req) begin
          data_write_reg <= data_write;
        end
      end
    end
  end

  // Status page generator; it touches no power or background control
  always @* begin
    gen_active_next = gen_active_reg;
    gen_idx_next = gen_idx_reg;
    if (page_start) begin
      gen_active_next = 1'b1; // [RULE3] [RULE4]
      gen_idx_next = 7'h00;
    end else if (gen_active_reg && fifo_in_ready) begin
      if (gen_idx_reg == `TSL_PAGE_LAST_WORD) begin
        gen_active_next = 1'b0;
      end
      gen_idx_next = gen_idx_reg + 7'h01;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gen_active_reg <= 1'b0;
      gen_idx_reg <= 7'h00;
    end else begin
      gen_active_reg <= gen_active_next;
      gen_idx_reg <= gen_idx_next;
    end
  end

  // Drive status sampling
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_state_reg <= `TSL_DS_ACTIVE;
    end else begin
      drive_state_reg <= drive_state_next;
    end
  end

  // Segment flag next value; a write or capacity change beats a write-same in the same cycle
  always @* begin
    seg_flag_next = seg_flag_reg;
    nv_store_next = 1'b0;
    if (!nv_loaded_reg) begin
      seg_flag_next = nv_seg_flag_in; // [RULE13]
    end else if (lba_write_in || max_address_set_in || config_overlay_in) begin
      seg_flag_next = 1'b0; // [RULE11] [RULE12]
      nv_store_next = seg_flag_reg; // [RULE13]
    end else if (write_same_done_in) begin
      seg_flag_next = 1'b1; // [RULE10]
      nv_store_next = !seg_flag_reg; // [RULE13]
    end
  end

  // Segment-initialized flag, restored from storage after reset release
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seg_flag_reg <= 1'b0;
      nv_loaded_reg <= 1'b0;
      nv_store_reg <= 1'b0;
    end else begin
      seg_flag_reg <= seg_flag_next;
      nv_loaded_reg <= 1'b1;
      nv_store_reg <= nv_store_next;
    end
  end

  assign avs_readdata_out = readdata_reg;
  assign avs_waitrequest_out = waitrequest_reg;
  assign nv_seg_flag_out = seg_flag_reg;
  assign nv_store_out = nv_store_reg;
  assign data_log_req_out = data_req_reg;
  assign data_log_write_out = data_write_reg;
endmodule // tsl_status_log

/* testbench/tsl_status_log_sva.sv */
// Port checker of the transport status log block
`timescale 1ns/10ps
module tsl_status_log_sva (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Bus
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  // Drive condition
  input wire standby_in,
  input wire sleep_in,
  input wire drive_self_test_in,
  input wire offline_data_collection_in,
  input wire command_transport_busy_in,
  input wire lba_write_in,
  input wire max_address_set_in,
  input wire config_overlay_in,
  input wire write_same_done_in,
  // Flag storage and data log
  input wire nv_seg_flag_in,
  input wire nv_seg_flag_out,
  input wire nv_store_out,
  input wire data_log_req_out,
  input wire data_log_write_out
);
  reg up_reg;
  wire clr_w = lba_write_in | max_address_set_in | config_overlay_in;
  // Skips the edge at which the stored flag is loaded
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  write_ans_a: assert property (avs_write_in && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("write not answered next cycle");
  read_ans_a: assert property (avs_read_in && avs_waitrequest_out |-> ##[1:40] !avs_waitrequest_out)
    else $error("read not answered in time");
  seg_set_a: assert property (up_reg && write_same_done_in && !clr_w |=> nv_seg_flag_out)
    else $error("segment flag not set");
  seg_clear_a: assert property (up_reg && clr_w |=> !nv_seg_flag_out)
    else $error("segment flag not cleared");
  flag_hold_a: assert property (up_reg && !clr_w && !write_same_done_in |=> $stable(nv_seg_flag_out))
    else $error("segment flag changed without cause");
  store_pulse_a: assert property (nv_store_out |-> nv_seg_flag_out != $past(nv_seg_flag_out))
    else $error("store pulse without flag change");
  data_pulse_a: assert property (data_log_req_out |=> !data_log_req_out)
    else $error("data request pulse too long");
  dir_hold_a: assert property ($changed(data_log_write_out) |-> data_log_req_out)
    else $error("direction changed without request");
  cover property (avs_read_in && !avs_waitrequest_out && avs_address_in == 5'h0c);
  cover property (data_log_req_out && data_log_write_out);
  cover property (nv_store_out);
endmodule // tsl_status_log_sva

/* testbench/tsl_host_model.sv */
// Host controller model: one Avalon-MM access per go pulse
`timescale 1ns/10ps
module tsl_host_model (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Access request from the bench
  input wire go_in,
  input wire wr_in,
  input wire [4:0] addr_in,
  input wire [31:0] wdata_in,
  output reg done_out,
  output reg [31:0] rdata_out,
  // Avalon-MM master
  output reg [4:0] avs_address_out,
  output reg avs_read_out,
  output reg avs_write_out,
  output reg [31:0] avs_writedata_out,
  input wire [31:0] avs_readdata_in,
  input wire avs_waitrequest_in
);
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_out <= 1'b0;
      rdata_out <= 32'h0;
      avs_address_out <= 5'h00;
      avs_read_out <= 1'b0;
      avs_write_out <= 1'b0;
      avs_writedata_out <= 32'h0;
    end else begin
      done_out <= 1'b0;
      if ((avs_read_out || avs_write_out) && !avs_waitrequest_in) begin
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        rdata_out <= avs_readdata_in;
        done_out <= 1'b1;
        // Released lines carry garbage
        avs_address_out <= ~avs_address_out;
        avs_writedata_out <= ~avs_writedata_out;
      end else if (go_in && !avs_read_out && !avs_write_out) begin
        avs_read_out <= !wr_in;
        avs_write_out <= wr_in;
        avs_address_out <= addr_in;
        avs_writedata_out <= wdata_in;
      end
    end
  end
endmodule // tsl_host_model

/* testbench/tsl_status_log_tb.sv */
// Self-checking bench of the transport status log block
`timescale 1ns/10ps
module tsl_status_log_tb;
  localparam logic [15:0] IMPLV = 16'h5a3c; // Arbitrary vendor version
  logic clk_in = 1'b0, resetn_in = 1'b0, nv_in = 1'b1, go = 1'b0, wr = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [4:0] st = 5'h00, addr = 5'h00;
  logic [31:0] wdata = 32'h0, x = 32'd33;
  wire [31:0] rdata, avs_wd, avs_rd;
  wire [4:0] avs_a;
  wire avs_r, avs_w, avs_wait, done, nv_out, nv_st, dreq, dwr;
  logic [31:0] expq[$];
  int fails = 0, cmp_count = 0, reqs = 0, stores = 0, i, k;
  always #2.5 clk_in = ~clk_in;
  tsl_host_model host (.clk_in(clk_in), .resetn_in(resetn_in), .go_in(go), .wr_in(wr),
    .addr_in(addr), .wdata_in(wdata), .done_out(done), .rdata_out(rdata),
    .avs_address_out(avs_a), .avs_read_out(avs_r), .avs_write_out(avs_w),
    .avs_writedata_out(avs_wd), .avs_readdata_in(avs_rd), .avs_waitrequest_in(avs_wait));
  tsl_status_log #(.IMPL_VERSION(IMPLV)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_a), .avs_read_in(avs_r), .avs_write_in(avs_w), .avs_writedata_in(avs_wd),
    .avs_readdata_out(avs_rd), .avs_waitrequest_out(avs_wait), .standby_in(st[0]),
    .sleep_in(st[1]), .drive_self_test_in(st[2]), .offline_data_collection_in(st[3]),
    .command_transport_busy_in(st[4]), .lba_write_in(ev[0]), .max_address_set_in(ev[1]),
    .config_overlay_in(ev[2]), .write_same_done_in(ev[3]), .nv_seg_flag_in(nv_in),
    .nv_seg_flag_out(nv_out), .nv_store_out(nv_st), .data_log_req_out(dreq),
    .data_log_write_out(dwr));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] pw(input int n, input logic [7:0] ds, input logic [15:0] ex);
    case (n)
      0: return {IMPLV, 16'h0003};
      1: return 32'h00010001;
      2: return {8'h00, ds, 16'h0000};
      3: return {ex, 16'h0000};
      default: return 32'h0;
    endcase
  endfunction
  task finish_test;
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e);
    end
  endtask
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    if (!w) expq.push_back(e);
    @(posedge clk_in);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 200) begin
      fails++;
      finish_test();
    end
  endtask
  task cmd(input logic [31:0] lo, input logic [31:0] hi);
    acc(1'b1, 5'h00, lo, 32'h0);
    acc(1'b1, 5'h04, hi, 32'h0);
  endtask
  // Each served read is compared against the oldest note
  always @(posedge clk_in) begin
    if (avs_r === 1'b1 && avs_wait === 1'b0) chk(avs_rd, expq.pop_front());
    if (dreq === 1'b1) reqs++;
    if (nv_st === 1'b1) stores++;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    acc(1'b0, 5'h08, 32'h0, 32'h8);
    for (k = 0; k < 7; k++) begin
      @(posedge clk_in);
      ev <= 4'(28'h8c82818 >> (k * 4));
      @(posedge clk_in);
      ev <= 4'h0;
      acc(1'b0, 5'h08, 32'h0, (k % 2 == 0) ? 32'h8 : 32'h0);
      chk({31'h0, nv_out}, (k % 2 == 0) ? 32'h1 : 32'h0);
    end
    chk(32'(stores), 32'h6);
    for (i = 0; i < 6; i++) begin
      st <= (i == 0) ? 5'h00 : 5'h01 << (i - 1);
      x = xs(x);
      if (i % 2 == 0) cmd({8'h4f, 8'he0, 8'h01, 8'hd5}, {8'hb0, 16'h0000, 8'hc2});
      else cmd({8'h00, 8'he0, 8'h01, x[7:0]}, {8'h2f, 16'h0000, x[15:8]});
      acc(1'b0, 5'h08, 32'h0, 32'hd);
      cmd({8'h4f, 8'he0, 8'h01, 8'hd5}, {8'hb0, 16'h0000, 8'hc2});
      acc(1'b0, 5'h08, 32'h0, 32'he);
      for (k = 0; k < 128; k++)
        acc(1'b0, 5'h0c, 32'h0, pw(k, i[7:0], (i == 5) ? 16'hffff : 16'h0));
      acc(1'b0, 5'h10, 32'h0, 32'(i));
      acc(1'b0, 5'h08, 32'h0, 32'ha);
    end
    st <= 5'h00;
    for (k = 0; k < 5; k++) begin
      x = xs(x);
      cmd({8'h00, 8'he1, (k == 4) ? 8'h02 : (k[0] ? 8'h08 : 8'h01), x[7:0]},
        {k[1] ? 8'h3f : 8'h2f, 24'h0});
      acc(1'b0, 5'h08, 32'h0, (k == 4) ? 32'ha : 32'h9);
      if (k < 4) chk({31'h0, dwr}, {31'h0, k[1]});
    end
    chk(32'(reqs), 32'h4);
    x = xs(x);
    acc(1'b1, 5'h00, x, 32'h0);
    acc(1'b0, 5'h00, 32'h0, x);
    acc(1'b0, 5'h14, 32'h0, 32'h0);
    acc(1'b1, 5'h08, x, 32'h0);
    acc(1'b0, 5'h08, 32'h0, 32'ha);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    nv_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    acc(1'b0, 5'h08, 32'h0, 32'h0);
    finish_test();
  end
endmodule // tsl_status_log_tb
bind tsl_status_log tsl_status_log_sva chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .standby_in(standby_in), .sleep_in(sleep_in),
  .drive_self_test_in(drive_self_test_in), .offline_data_collection_in(offline_data_collection_in),
  .command_transport_busy_in(command_transport_busy_in), .lba_write_in(lba_write_in),
  .max_address_set_in(max_address_set_in), .config_overlay_in(config_overlay_in),
  .write_same_done_in(write_same_done_in), .nv_seg_flag_in(nv_seg_flag_in),
  .nv_seg_flag_out(nv_seg_flag_out), .nv_store_out(nv_store_out),
  .data_log_req_out(data_log_req_out), .data_log_write_out(data_log_write_out));
